/* rtl/cs_pkg.sv */
package cs_pkg;

    // time base: clock period and 1 MHz tick period in ns
    localparam int CS_CLK_PERIOD_NS = 8;
    localparam int CS_TB_PERIOD_NS = 1000;
    localparam int CS_TB_DIV = CS_TB_PERIOD_NS / CS_CLK_PERIOD_NS;
    localparam int CS_PRE_W = 8; // prescaler width, holds divides up to 256

    // register byte offsets
    localparam logic [7:0] CS_OFF_CTRL = 8'h00;
    localparam logic [7:0] CS_OFF_CMD = 8'h04;
    localparam logic [7:0] CS_OFF_LOW = 8'h08;
    localparam logic [7:0] CS_OFF_HIGH = 8'h0C;
    localparam logic [7:0] CS_OFF_STAT = 8'h10;

    // control field positions
    localparam int CS_CTRL_SRC_LSB = 0;
    localparam int CS_CTRL_TRIG_BIT = 2;
    localparam int CS_CTRL_GATE_BIT = 3;
    localparam int CS_CTRL_CASC_BIT = 4;
    // command field positions (write only, self clearing)
    localparam int CS_CMD_START_BIT = 0;
    localparam int CS_CMD_STOP_BIT = 1;
    localparam int CS_CMD_CONV_BIT = 2;
    // status field positions
    localparam int CS_STAT_DONE_BIT = 0;
    localparam int CS_STAT_ST_LSB = 1;
    localparam int CS_STAT_TB_BIT = 3;
    localparam int CS_STAT_TG_BIT = 4;
    localparam int CS_STAT_EXT_BIT = 5;

    // reset values
    localparam logic [15:0] CS_DIV_RST = 16'h0000; // zero loads as 65536
    localparam logic [16:0] CS_FULL_CNT = 17'h10000;

    // conversion start source; code 2'b11 acts as host command
    typedef enum logic [1:0] {
        CS_SRC_SW = 2'b00,
        CS_SRC_INT = 2'b01,
        CS_SRC_EXT = 2'b10
    } cs_src_t;

    // acquisition sequencer states
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WAIT_TRIG = 2'b01,
        CS_RUN = 2'b10
    } cs_seq_t;

    // ahb-lite request group from the master
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } cs_ahb_req_t;

    // complete state of the sequencer
    typedef struct packed {
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic tg_s1;
        logic tg_s2;
        logic tg_s3;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic [1:0] src;
        logic trig_en;
        logic gate_en;
        logic cascade;
        logic [15:0] div_low;
        logic [15:0] div_high;
        cs_seq_t st;
        logic [CS_PRE_W-1:0] pre_cnt;
        logic half;
        logic stage_int;
        logic [16:0] low_cnt;
        logic [16:0] high_cnt;
        logic done;
        logic conv_start;
        logic master_out;
        logic ext_irq;
    } cs_state_t;

endpackage

/* rtl/cs_start_seq.sv */
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module cs_start_seq #(
    parameter int TB_DIV = cs_pkg::CS_TB_DIV, // clk cycles per 1 MHz tick
    parameter bit BASE_VARIANT = 1'b0, // 1: low stage on bus/2 until internal pacing
    parameter bit MASTER_CAPABLE = 1'b1 // 1: each pacing interval event (low stage, or high stage in cascade) drives the pace pin
) (
    input wire logic clk, // 125 MHz system and bus clock
    input wire logic reset_n, // asynchronous reset, active low
    input wire cs_pkg::cs_ahb_req_t ahb_req, // ahb-lite request group
    output logic hreadyout, // slave ready, always high
    output logic [31:0] hrdata, // read data
    output logic hresp, // response, always okay
    input wire logic ext_pace_clock_in, // external pacing clock pin
    input wire logic trigger_gate_in, // shared trigger and gate pin
    input wire logic conv_done_in, // converter finished, one-cycle pulse
    output logic conv_start_out, // start one conversion, one-cycle pulse
    output logic master_pace_out, // pace clock for other boards
    output logic ext_irq_req_out // interrupt request from pacing pin
);

    // refuse prescaler settings the counter cannot hold
    if (TB_DIV < 2 || TB_DIV > (1 << cs_pkg::CS_PRE_W)) begin : g_bad_div
        $error("TB_DIV out of range");
    end

    localparam logic [cs_pkg::CS_PRE_W-1:0] PRE_LAST = cs_pkg::CS_PRE_W'(TB_DIV - 1);

    cs_pkg::cs_state_t s_r; // registered state
    cs_pkg::cs_state_t s_nxt; // next state

    // decoded events and strobes of the current cycle
    logic ext_fall; // falling edge of pacing clock
    logic tg_rise; // rising edge of trigger/gate
    logic tb_tick; // 1 MHz time base tick
    logic low_tick; // low stage clock enable
    logic acc; // address phase accepted
    logic cmd_start; // start acquisition written
    logic cmd_stop; // stop acquisition written
    logic cmd_conv; // host conversion command written
    logic arm; // acquisition begins this cycle
    logic gate_on; // gate qualifies pacing
    logic gate_ok; // gate allows conversions now
    logic gate_rise; // gate just opened
    logic reload; // reload both stages and prescaler
    logic conv; // start a conversion
    logic pace; // interval event for the pace pin
    logic is_int; // internal pacing selected
    logic is_ext; // external pacing selected

    // a programmed zero means the full 65536 count
    function automatic logic [16:0] load_val(input logic [15:0] v);
        load_val = (v == 16'h0000) ? cs_pkg::CS_FULL_CNT : {1'b0, v};
    endfunction

    // all next-state logic
    always_comb begin
        s_nxt = s_r;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        cmd_conv = 1'b0;
        arm = 1'b0;
        reload = 1'b0;
        conv = 1'b0;
        pace = 1'b0;

        // two-flop synchronisers, third flop only for edge detect
        s_nxt.ext_s1 = ext_pace_clock_in;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_s3 = s_r.ext_s2;
        s_nxt.tg_s1 = trigger_gate_in;
        s_nxt.tg_s2 = s_r.tg_s1;
        s_nxt.tg_s3 = s_r.tg_s2;
        ext_fall = s_r.ext_s3 & ~s_r.ext_s2;
        tg_rise = ~s_r.tg_s3 & s_r.tg_s2;

        // 1 MHz time base from the system clock
        tb_tick = (s_r.pre_cnt == PRE_LAST);
        s_nxt.pre_cnt = tb_tick ? '0 : s_r.pre_cnt + 1'b1;
        s_nxt.half = ~s_r.half;
        // base variant keeps the low stage on bus/2 until internal pacing is chosen
        low_tick = (s_r.stage_int || !BASE_VARIANT) ? tb_tick : s_r.half;

        // address phase: reads are answered from a flop in the data phase
        acc = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        s_nxt.wr_pend = acc & ahb_req.hwrite;
        if (acc) begin
            s_nxt.wr_addr = ahb_req.haddr[7:0];
        end
        if (acc && !ahb_req.hwrite) begin
            unique case (ahb_req.haddr[7:0])
                cs_pkg::CS_OFF_CTRL: begin
                    s_nxt.hrdata = {27'h0000000, s_r.cascade, s_r.gate_en,
                                    s_r.trig_en, s_r.src};
                end
                cs_pkg::CS_OFF_LOW: begin
                    s_nxt.hrdata = {16'h0000, s_r.div_low};
                end
                cs_pkg::CS_OFF_HIGH: begin
                    s_nxt.hrdata = {16'h0000, s_r.div_high};
                end
                cs_pkg::CS_OFF_STAT: begin
                    // host polls the done bit before reading a result
                    s_nxt.hrdata = 32'h00000000;
                    s_nxt.hrdata[cs_pkg::CS_STAT_DONE_BIT] = s_r.done;
                    s_nxt.hrdata[cs_pkg::CS_STAT_ST_LSB +: 2] = s_r.st;
                    s_nxt.hrdata[cs_pkg::CS_STAT_TB_BIT] = s_r.stage_int;
                    s_nxt.hrdata[cs_pkg::CS_STAT_TG_BIT] = s_r.tg_s2;
                    s_nxt.hrdata[cs_pkg::CS_STAT_EXT_BIT] = s_r.ext_s2;
                end
                default: begin
                    // command register and unmapped words read zero
                    s_nxt.hrdata = 32'h00000000;
                end
            endcase
        end

        // data phase of a write
        if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
                cs_pkg::CS_OFF_CTRL: begin
                    s_nxt.src = ahb_req.hwdata[cs_pkg::CS_CTRL_SRC_LSB +: 2];
                    s_nxt.trig_en = ahb_req.hwdata[cs_pkg::CS_CTRL_TRIG_BIT];
                    s_nxt.gate_en = ahb_req.hwdata[cs_pkg::CS_CTRL_GATE_BIT];
                    s_nxt.cascade = ahb_req.hwdata[cs_pkg::CS_CTRL_CASC_BIT];
                    // the switch to the 1 MHz base is one way until reset
                    if (ahb_req.hwdata[cs_pkg::CS_CTRL_SRC_LSB +: 2] == cs_pkg::CS_SRC_INT) begin
                        s_nxt.stage_int = 1'b1;
                    end
                end
                cs_pkg::CS_OFF_CMD: begin
                    cmd_start = ahb_req.hwdata[cs_pkg::CS_CMD_START_BIT];
                    cmd_stop = ahb_req.hwdata[cs_pkg::CS_CMD_STOP_BIT];
                    cmd_conv = ahb_req.hwdata[cs_pkg::CS_CMD_CONV_BIT];
                end
                cs_pkg::CS_OFF_LOW: begin
                    s_nxt.div_low = ahb_req.hwdata[15:0];
                end
                cs_pkg::CS_OFF_HIGH: begin
                    s_nxt.div_high = ahb_req.hwdata[15:0];
                end
                default: begin
                    // writes to read-only or unmapped words are dropped
                end
            endcase
        end

        is_int = (s_r.src == cs_pkg::CS_SRC_INT);
        is_ext = (s_r.src == cs_pkg::CS_SRC_EXT);
        // the gate is ignored while the trigger is enabled, they share one pin
        gate_on = s_r.gate_en & ~s_r.trig_en;
        gate_ok = ~gate_on | s_r.tg_s2;
        gate_rise = gate_on & tg_rise;

        // acquisition sequencer
        unique case (s_r.st)
            cs_pkg::CS_IDLE: begin
                if (cmd_start && (is_int || is_ext)) begin
                    if (s_r.trig_en) begin
                        s_nxt.st = cs_pkg::CS_WAIT_TRIG;
                    end else begin
                        s_nxt.st = cs_pkg::CS_RUN;
                        arm = 1'b1;
                    end
                end
            end
            cs_pkg::CS_WAIT_TRIG: begin
                if (tg_rise) begin
                    s_nxt.st = cs_pkg::CS_RUN;
                    arm = 1'b1;
                end
            end
            cs_pkg::CS_RUN: begin
                // runs until stopped
            end
            default: begin
                s_nxt.st = cs_pkg::CS_IDLE;
            end
        endcase
        if (cmd_stop) begin
            s_nxt.st = cs_pkg::CS_IDLE;
            arm = 1'b0;
        end

        // pacing; external pacing only arms here and waits for a falling edge
        if (arm) begin
            if (is_int) begin
                reload = 1'b1;
                // a closed gate delays the first conversion to its rise
                if (gate_ok) begin
                    conv = 1'b1;
                    pace = 1'b1;
                end
            end
        end else if (s_r.st == cs_pkg::CS_RUN && is_int) begin
            if (gate_rise) begin
                reload = 1'b1;
                conv = 1'b1;
                pace = 1'b1;
            end else if (gate_ok && low_tick) begin
                // counters hold while the gate is low
                if (s_r.low_cnt == 17'h00001) begin
                    s_nxt.low_cnt = load_val(s_r.div_low);
                    if (!s_r.cascade) begin
                        conv = 1'b1;
                        pace = 1'b1;
                    end else if (s_r.high_cnt == 17'h00001) begin
                        conv = 1'b1;
                        pace = 1'b1;
                        s_nxt.high_cnt = load_val(s_r.div_high);
                    end else begin
                        s_nxt.high_cnt = s_r.high_cnt - 17'h00001;
                    end
                end else begin
                    s_nxt.low_cnt = s_r.low_cnt - 17'h00001;
                end
            end
        end else if (s_r.st == cs_pkg::CS_RUN && is_ext) begin
            // edges seen while the gate is low are skipped, not delayed
            if (ext_fall && gate_ok) begin
                conv = 1'b1;
            end
        end else if (low_tick) begin
            // outside a running internal or external pacing the low stage free-runs on its own clock
            if (s_r.low_cnt == 17'h00001) begin
                s_nxt.low_cnt = load_val(s_r.div_low);
            end else begin
                s_nxt.low_cnt = s_r.low_cnt - 17'h00001;
            end
        end
        if (reload) begin
            // restarting the prescaler makes the first interval exact
            s_nxt.low_cnt = load_val(s_r.div_low);
            s_nxt.high_cnt = load_val(s_r.div_high);
            s_nxt.pre_cnt = '0;
            s_nxt.half = 1'b0;
        end

        // host-command conversions only in host-command mode
        if (cmd_conv && !is_int && !is_ext) begin
            conv = 1'b1;
        end
        s_nxt.conv_start = conv;

        // done flag: a finish in the same cycle as a start wins
        if (conv) begin
            s_nxt.done = 1'b0;
        end
        if (conv_done_in) begin
            s_nxt.done = 1'b1;
        end

        // pace pin falls on each interval event and rises at the next tick,
        // so a slave board sees a low of about one microsecond
        if (pace && MASTER_CAPABLE) begin
            s_nxt.master_out = 1'b0;
        end else if (tb_tick) begin
            s_nxt.master_out = 1'b1;
        end

        // the pacing pin is a plain interrupt source only when not pacing
        s_nxt.ext_irq = ext_fall & ~is_ext;
    end

    // state register; reset selects host-command starts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r.ext_s1 <= 1'b0;
            s_r.ext_s2 <= 1'b0;
            s_r.ext_s3 <= 1'b0;
            s_r.tg_s1 <= 1'b0;
            s_r.tg_s2 <= 1'b0;
            s_r.tg_s3 <= 1'b0;
            s_r.wr_pend <= 1'b0;
            s_r.wr_addr <= 8'h00;
            s_r.hrdata <= 32'h00000000;
            s_r.hreadyout <= 1'b1;
            s_r.hresp <= 1'b0;
            s_r.src <= cs_pkg::CS_SRC_SW;
            s_r.trig_en <= 1'b0;
            s_r.gate_en <= 1'b0;
            s_r.cascade <= 1'b0;
            s_r.div_low <= cs_pkg::CS_DIV_RST;
            s_r.div_high <= cs_pkg::CS_DIV_RST;
            s_r.st <= cs_pkg::CS_IDLE;
            s_r.pre_cnt <= '0;
            s_r.half <= 1'b0;
            s_r.stage_int <= 1'b0;
            s_r.low_cnt <= cs_pkg::CS_FULL_CNT;
            s_r.high_cnt <= cs_pkg::CS_FULL_CNT;
            s_r.done <= 1'b0;
            s_r.conv_start <= 1'b0;
            s_r.master_out <= 1'b1;
            s_r.ext_irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign hreadyout = s_r.hreadyout;
    assign hrdata = s_r.hrdata;
    assign hresp = s_r.hresp;
    assign conv_start_out = s_r.conv_start;
    assign master_pace_out = s_r.master_out;
    assign ext_irq_req_out = s_r.ext_irq;

endmodule

/* testbench/adc_conversion_start_sequencer_tb_top.sv */
`timescale 1ns/1ps
module adc_conversion_start_sequencer_tb_top;
    localparam int TB = 4; // shortened 1 MHz tick
    localparam logic [7:0] CTL = cs_pkg::CS_OFF_CTRL; // register offsets
    localparam logic [7:0] CMD = cs_pkg::CS_OFF_CMD;
    localparam logic [7:0] LOW = cs_pkg::CS_OFF_LOW;
    localparam logic [7:0] STAT = cs_pkg::CS_OFF_STAT;
    logic clk = 1'h0; // 125 MHz clock
    logic reset_n = 1'h0; // held low ten cycles
    cs_pkg::cs_ahb_req_t req = '0; // master drive, hready replaced below
    cs_pkg::cs_ahb_req_t bus; // request group as the slave sees it
    logic hreadyout, hresp, ext_clk, tg, done, conv, pace, irq; // device pins
    logic pace_d = 1'h1; // pace pin one edge ago, for fall counting
    int fall_n = 0; // pace pin falls since the last start command
    logic [31:0] hrdata; // read data
    logic [31:0] rd; // last read data
    logic [31:0] ex[3] = '{32'h00000002, 32'h00000006, 32'h0000000A}; // external modes
    int e0[3] = '{1, 0, 0}; // starts before the trigger or gate opens
    int err_total = 0; // mismatches
    int check_count = 0; // comparisons
    int seed = 1530; // random seed
    int cyc = 0; // clock edges seen
    int irq_n = 0; // interrupt pulses seen
    int lo, t0, n; // low count, reference cycle, saved count
    int q[$]; // cycles of conversion starts
    always #4 clk = ~clk; // 8 ns period
    assign bus = {req[$bits(req)-1:1], hreadyout}; // sole slave: its ready is hready
    cs_start_seq #(.TB_DIV(TB)) u_dut (
        .clk(clk), .reset_n(reset_n), .ahb_req(bus), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .ext_pace_clock_in(ext_clk), .trigger_gate_in(tg),
        .conv_done_in(done), .conv_start_out(conv), .master_pace_out(pace),
        .ext_irq_req_out(irq)
    );
    cs_pin_src #(.HALF(60)) u_src (
        .clk(clk), .conv_start_out(conv), .ext_pace_clock_in(ext_clk),
        .trigger_gate_in(tg), .conv_done_in(done)
    );
    // log conversion starts and interrupt pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv === 1'h1) q.push_back(cyc);
        if (irq === 1'h1) irq_n++;
        pace_d <= pace;
        if (pace_d === 1'h1 && pace === 1'h0) fall_n++;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // single word transfer: address phase until ready, then data phase until ready
    task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [23:0] up; // undecoded upper address bits, random
        logic [31:0] wd; // write data, random filler on reads
        up = 24'($random(seed));
        wd = w ? d : 32'($random(seed));
        req <= '{1'h1, {up, a}, 2'h2, w, 3'h2, req.hwdata, 1'h1};
        do @(posedge clk); while (hreadyout !== 1'h1);
        req <= '{1'h0, {up, a}, 2'h0, 1'h0, 3'h2, wd, 1'h1};
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            err_total++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus_op(1'h0, a, 32'h00000000);
        chk32(rd & m, e);
        chk_n(hresp, 0);
    endtask
    // select a mode and start acquisition, remembering when
    task automatic go(input logic [31:0] c);
        bus_op(1'h1, CTL, c);
        q.delete();
        fall_n = 0;
        bus_op(1'h1, CMD, 32'h00000001);
        t0 = cyc;
    endtask
    task automatic halt();
        bus_op(1'h1, CMD, 32'h00000002);
    endtask
    // start number k came no later than lim cycles after t0
    task automatic first_at(input int k, input int lim);
        chk_n(q.size() > k && q[k] - t0 <= lim, 1);
    endtask
    task automatic gaps(input int k, input int g);
        chk_n(q.size() >= k, 1);
        for (int i = 1; i < k && i < q.size(); i++) chk_n(q[i] - q[i - 1], g);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        tick(10);
        reset_n <= 1'h1;
        tick(1);
        rd_chk(CTL, 32'hFFFFFFFF, 32'h00000000);
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h00000000); // unmapped place reads zero
        rd_chk(CMD, 32'hFFFFFFFF, 32'h00000000); // command word reads zero
        // host command with a prompt converter: one start, then done
        u_src.done_dly = 1;
        q.delete();
        bus_op(1'h1, CMD, 32'h00000004);
        tick(8);
        chk_n(q.size(), 1);
        rd_chk(STAT, 32'h00000001, 32'h00000001);
        // slow converter: done clears at the start, returns at the finish
        u_src.done_dly = 20;
        bus_op(1'h1, CMD, 32'h00000004);
        tick(3);
        rd_chk(STAT, 32'h00000001, 32'h00000000);
        tick(25);
        rd_chk(STAT, 32'h00000001, 32'h00000001);
        // internal pacing, normal mode, random count
        lo = 6 + ($random(seed) & 7);
        bus_op(1'h1, LOW, lo);
        rd_chk(LOW, 32'h0000FFFF, lo); // count reads back
        go(32'h00000001);
        tick(lo * TB * 3 + 10);
        halt();
        first_at(0, 2);
        gaps(4, lo * TB);
        chk_n(fall_n, q.size());
        // cascade: low 3 and high 2 give one start per six ticks
        bus_op(1'h1, LOW, 32'h00000003);
        bus_op(1'h1, cs_pkg::CS_OFF_HIGH, 32'h00000002);
        go(32'h00000011);
        tick(6 * TB * 3 + 10);
        halt();
        gaps(4, 6 * TB);
        // trigger with internal pacing: idle until the rising edge
        bus_op(1'h1, LOW, lo);
        go(32'h00000005);
        tick(40);
        chk_n(q.size(), 0);
        u_src.set_tg(1'h1);
        t0 = cyc;
        tick(lo * TB + 12);
        halt();
        first_at(0, 6);
        gaps(2, lo * TB);
        u_src.set_tg(1'h0);
        // gated internal pacing: hold while low, reload and start on each rise
        go(32'h00000009);
        tick(40);
        chk_n(q.size(), 0);
        u_src.set_tg(1'h1);
        t0 = cyc;
        tick(lo * TB * 2 + 10);
        first_at(0, 6);
        gaps(3, lo * TB);
        u_src.set_tg(1'h0);
        tick(4);
        n = q.size();
        tick(lo * TB * 2);
        chk_n(q.size(), n);
        u_src.set_tg(1'h1);
        t0 = cyc;
        tick(8);
        halt();
        first_at(n, 6);
        u_src.set_tg(1'h0);
        // external pacing plain, armed by a trigger edge, opened by the gate
        irq_n = 0;
        for (int i = 0; i < 3; i++) begin
            go(ex[i]);
            u_src.ext_falls(1);
            chk_n(q.size(), e0[i]);
            u_src.set_tg(1'h1);
            u_src.ext_falls(2);
            halt();
            chk_n(q.size(), e0[i] + 2);
            u_src.set_tg(1'h0);
        end
        chk_n(irq_n, 0);
        // host source again: the pin now raises one request per fall
        bus_op(1'h1, CTL, 32'h00000000);
        u_src.ext_falls(1);
        chk_n(irq_n, 1);
        close_out();
    end
    // cut a hang short: the sequence needs about two thousand cycles
    initial begin
        tick(20000);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
endmodule

/* testbench/cs_pin_src.sv */
`timescale 1ns/1ps
module cs_pin_src #(
    parameter int HALF = 60 // half period in clk cycles, period above 25 ticks
) (
    input wire logic clk, // bench clock
    input wire logic conv_start_out, // start pulse from the sequencer
    output logic ext_pace_clock_in, // pacing clock, stands high between bursts
    output logic trigger_gate_in, // shared trigger and gate level
    output logic conv_done_in // converter finished pulse
);
    int done_dly = 3; // converter busy time, prompt or slow as the bench sets
    int left = 0; // cycles until the stand-in converter finishes
    initial begin
        ext_pace_clock_in = 1'h1;
        trigger_gate_in = 1'h0;
        conv_done_in = 1'h0;
    end
    // converter stand-in: one done pulse per start; a new start restarts it
    always @(posedge clk) begin
        conv_done_in <= (left == 1);
        if (conv_start_out === 1'h1) begin
            left <= done_dly;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    // n pacing clock cycles, each low for HALF and back high
    task automatic ext_falls(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (HALF) @(posedge clk);
            ext_pace_clock_in <= 1'h0;
            repeat (HALF) @(posedge clk);
            ext_pace_clock_in <= 1'h1;
        end
    endtask
    task automatic set_tg(input logic v);
        @(posedge clk);
        trigger_gate_in <= v;
    endtask
endmodule

/* testbench/cs_start_seq_checker.sv */
`timescale 1ns/1ps
module cs_start_seq_checker #(
    parameter int TB_DIV = 125 // clk cycles per 1 MHz tick
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire cs_pkg::cs_ahb_req_t ahb_req, // bus request group
    input wire logic ext_pace_clock_in, // external pacing pin
    input wire logic trigger_gate_in, // trigger and gate pin
    input wire logic conv_start_out, // conversion start pulse
    input wire logic master_pace_out, // pace clock to other boards
    input wire logic ext_irq_req_out // interrupt request pulse
);
    localparam int PACE_MAX = TB_DIV + 2; // low phase ends by the next tick
    logic wp; // write data phase pending
    logic [7:0] wa; // address of that write
    logic [4:0] ctl; // shadow of the control word
    logic host; // host-command source
    logic cmd_conv; // host convert command in its data phase
    logic gate_on; // gated hardware pacing
    assign host = ctl[1] ~^ ctl[0]; // codes 0 and 3 both mean host
    assign cmd_conv = wp && wa == cs_pkg::CS_OFF_CMD && host
        && ahb_req.hwdata[cs_pkg::CS_CMD_CONV_BIT];
    assign gate_on = ctl[3] && !ctl[2] && (ctl[1] ^ ctl[0]); // trigger wins over gate
    // snoop bus writes so the mode is known without looking inside
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wp <= 1'h0;
            wa <= 8'h00;
            ctl <= 5'h00;
        end else begin
            wp <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite;
            if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
                wa <= ahb_req.haddr[7:0];
            end
            if (wp && wa == cs_pkg::CS_OFF_CTRL) begin
                ctl <= ahb_req.hwdata[4:0];
            end
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    reset_out_a: assert property ($rose(reset_n) |-> !conv_start_out && master_pace_out)
        else $error("outputs not idle after reset");
    start_once_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse longer than one cycle");
    irq_cause_a: assert property (ext_irq_req_out |-> !$past(ext_pace_clock_in, 2))
        else $error("interrupt without a falling pin");
    ext_noirq_a: assert property ((ctl[1:0] == 2'h2) [*6] |-> !ext_irq_req_out)
        else $error("interrupt while pin paces");
    host_conv_a: assert property (cmd_conv |=> conv_start_out)
        else $error("host command gave no start");
    host_only_a: assert property (host [*3] ##0 conv_start_out |-> $past(cmd_conv))
        else $error("start without host command");
    ext_edge_a: assert property ((ctl[1:0] == 2'h2) [*6] ##0 conv_start_out
        |-> !$past(ext_pace_clock_in, 2)) else $error("start off a falling edge");
    gate_block_a: assert property (gate_on [*6] ##0 conv_start_out
        |-> $past(trigger_gate_in, 3)) else $error("start while gate closed");
    pace_low_a: assert property ($fell(master_pace_out) |-> ##[1:PACE_MAX] master_pace_out)
        else $error("pace output stuck low");
endmodule
bind cs_start_seq cs_start_seq_checker #(.TB_DIV(TB_DIV)) u_chk (
    .clk(clk), .reset_n(reset_n), .ahb_req(ahb_req), .ext_pace_clock_in(ext_pace_clock_in),
    .trigger_gate_in(trigger_gate_in), .conv_start_out(conv_start_out),
    .master_pace_out(master_pace_out), .ext_irq_req_out(ext_irq_req_out)
);
